// file: pch_config_regs.sv
`timescale 1ns/1ps


module pch_config_regs
  import pch_pkg::*;
#(
  // revision code, value is arbitrary
  parameter logic [7:0] REVISION = 8'h01
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // configuration access
  input  pch_cfg_req_type        cfg,
  output logic                   cfg_ack_q,
  output logic [31:0]            cfg_rdata_q,
  // bus master burst control
  input  wire logic              mst_burst,
  input  wire logic              gnt_n,
  output logic                   lat_expired_q,
  output logic                   burst_stop_q,
  // decode and shared control outputs
  output logic [19:0]            mem_base_q,
  output logic                   compat_mode_a_enable_q,
  output logic                   compat_mode_b_enable_q,
  output logic                   board_vendor_write_enable_q,
  // product data word link
  input  wire logic [31:0]       pd_word_in,
  output logic [31:0]            pd_word_q,
  output logic                   pd_word_load_q,
  // eeprom byte port
  output pch_ee_req_type         ee_q,
  input  wire logic              ee_ack,
  input  wire logic [7:0]        ee_rdata
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]  lat_timer_q;
  logic [7:0]  lat_count_q;
  logic        burst_d1_q;
  logic [31:0] board_q;
  logic [7:0]  irq_line_q;
  logic [2:0]  ctrl_q;
  logic        product_data_done_flag_q;
  logic [7:0]  product_data_byte_address_q;
  logic        pd_busy;
  logic        pd_rd_done;
  logic        pd_wr_done;
  logic        pd_start;
  logic [7:0]  byte_offset;
  logic        wr_ok;
  logic [31:0] rd_word;
  logic [31:0] board_word;
  logic [3:0]  board_lane_we;

  assign byte_offset = {cfg.dw_addr, 2'b00};
  assign wr_ok       = cfg.wr & ~cfg.rd;

  // ---------------------------------------------------------------
  // latency timer register and counter
  // ---------------------------------------------------------------
  // writable timer byte
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lat_timer_q <= PCH_LAT_RESET;
    end else if (wr_ok && byte_offset == PCH_OFS_HDRLAT && cfg.be[1]) begin
      lat_timer_q <= cfg.wdata[15:8];
    end
  end

  // counter reloads at each burst start, counts pci clocks down
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lat_count_q   <= 8'h00;
      burst_d1_q    <= 1'b0;
      lat_expired_q <= 1'b0;
    end else begin
      burst_d1_q <= mst_burst;
      if (mst_burst && !burst_d1_q) begin
        lat_count_q   <= lat_timer_q;
        lat_expired_q <= (lat_timer_q == 8'h00);
      end else if (mst_burst) begin
        if (lat_count_q != 8'h00) begin
          lat_count_q <= lat_count_q - 8'h01;
        end
        lat_expired_q <= (lat_count_q <= 8'h01);
      end else begin
        lat_expired_q <= 1'b0;
      end
    end
  end

  // stop once expired and grant gone
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      burst_stop_q <= 1'b0;
    end else begin
      burst_stop_q <= mst_burst & lat_expired_q & gnt_n;
    end
  end

  // ---------------------------------------------------------------
  // memory window base
  // ---------------------------------------------------------------
  // upper bits kept for decoding, per byte lane
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_base_q <= 20'h00000;
    end else if (wr_ok && byte_offset == PCH_OFS_BASE) begin
      if (cfg.be[1]) begin
        mem_base_q[3:0] <= cfg.wdata[15:12];
      end
      if (cfg.be[2]) begin
        mem_base_q[11:4] <= cfg.wdata[23:16];
      end
      if (cfg.be[3]) begin
        mem_base_q[19:12] <= cfg.wdata[31:24];
      end
    end
  end

  // ---------------------------------------------------------------
  // board identifiers
  // ---------------------------------------------------------------
  // vendor lanes gated by the shared enable
  assign board_lane_we[0] = ctrl_q[PCH_CTRL_VWE_BIT];
  assign board_lane_we[1] = ctrl_q[PCH_CTRL_VWE_BIT];
  assign board_lane_we[2] = 1'b1;
  assign board_lane_we[3] = 1'b1;
  assign board_word       = board_q;

  // one process per lane of the identifier word; each lane owns
  // its own byte, so no two processes ever drive the same bits
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_board
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          // lanes 0 and 1 hold the vendor id, lanes 2 and 3 the board id
          board_q[8*lane +: 8] <= PCH_BOARD_RESET[8*(lane%2) +: 8];
        end else if (wr_ok && byte_offset == PCH_OFS_BOARD &&
                     cfg.be[lane] && board_lane_we[lane]) begin
          board_q[8*lane +: 8] <= cfg.wdata[8*lane +: 8];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt line and device control
  // ---------------------------------------------------------------
  // storage only, no hardware effect
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_line_q <= 8'h00;
    end else if (wr_ok && byte_offset == PCH_OFS_IRQ && cfg.be[0]) begin
      irq_line_q <= cfg.wdata[7:0];
    end
  end

  // three control bits; upper bits not stored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= PCH_CTRL_RESET;
    end else if (wr_ok && byte_offset == PCH_OFS_CTRL && cfg.be[0]) begin
      ctrl_q <= cfg.wdata[2:0];
    end
  end

  // shared with function 1 through outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      compat_mode_a_enable_q      <= 1'b0;
      compat_mode_b_enable_q      <= 1'b0;
      board_vendor_write_enable_q <= 1'b0;
    end else begin
      compat_mode_a_enable_q      <= ctrl_q[PCH_CTRL_CMA_BIT];
      compat_mode_b_enable_q      <= ctrl_q[PCH_CTRL_CMB_BIT];
      board_vendor_write_enable_q <= ctrl_q[PCH_CTRL_VWE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // product data capability
  // ---------------------------------------------------------------
  // a write to the top byte starts a transfer; ignored while busy
  assign pd_start = wr_ok && byte_offset == PCH_OFS_PDCAP &&
                    cfg.be[3] && !pd_busy;

  // only the low address byte is kept
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      product_data_byte_address_q <= 8'h00;
    end else if (wr_ok && byte_offset == PCH_OFS_PDCAP &&
                 cfg.be[2] && !pd_busy) begin
      product_data_byte_address_q <= cfg.wdata[23:16];
    end
  end

  // completion beats a software write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      product_data_done_flag_q <= 1'b0;
    end else begin
      if (pd_start) begin
        product_data_done_flag_q <= cfg.wdata[PCH_PD_FLAG_BIT];
      end
      // set after a four byte read
      if (pd_rd_done) begin
        product_data_done_flag_q <= 1'b1;
      end
      // clear after a four byte write
      if (pd_wr_done) begin
        product_data_done_flag_q <= 1'b0;
      end
    end
  end

  // load strobe for the data word, same cycle as the flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pd_word_load_q <= 1'b0;
    end else begin
      pd_word_load_q <= pd_rd_done;
    end
  end

  // byte sequencing lives in the engine
  pch_pd_engine u_pd_engine (
    .clock      (clock),
    .resetn     (resetn),
    .start      (pd_start),
    .start_we   (cfg.wdata[PCH_PD_FLAG_BIT]),
    .start_addr ((cfg.be[2]) ? cfg.wdata[23:16] : product_data_byte_address_q),
    .word_in    (pd_word_in),
    .ee_q       (ee_q),
    .ee_ack     (ee_ack),
    .ee_rdata   (ee_rdata),
    .busy_q     (pd_busy),
    .rd_done_q  (pd_rd_done),
    .wr_done_q  (pd_wr_done),
    .word_q     (pd_word_q)
  );

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  // unlisted offsets and reserved bits give zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (byte_offset)
      PCH_OFS_CLASS: begin
        rd_word = {PCH_CLASS_CODE, REVISION};
      end
      PCH_OFS_HDRLAT: begin
        rd_word = {8'h00, PCH_HDR_TYPE, lat_timer_q, 8'h00};
      end
      PCH_OFS_BASE: begin
        rd_word = {mem_base_q, PCH_BASE_LOW};
      end
      PCH_OFS_BOARD: begin
        rd_word = board_word;
      end
      PCH_OFS_CAPPTR: begin
        rd_word = {24'h000000, PCH_CAP_PTR};
      end
      PCH_OFS_IRQ: begin
        rd_word = {PCH_MAX_LAT, PCH_MIN_GNT, PCH_IRQ_PIN, irq_line_q};
      end
      PCH_OFS_CTRL: begin
        rd_word = {29'h0, ctrl_q};
      end
      PCH_OFS_PDCAP: begin
        rd_word = {product_data_done_flag_q, 7'h00,
                   product_data_byte_address_q,
                   PCH_PD_NEXT_PTR, PCH_PD_CAP_CODE};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end else begin
      cfg_ack_q <= cfg.rd | cfg.wr;
      if (cfg.rd) begin
        cfg_rdata_q <= rd_word;
      end
    end
  end

endmodule : pch_config_regs

// file: pch_pkg.sv
package pch_pkg;

  // ---------------------------------------------------------------
  // register byte offsets in the header
  // ---------------------------------------------------------------
  localparam logic [7:0] PCH_OFS_CLASS  = 8'h08;
  localparam logic [7:0] PCH_OFS_HDRLAT = 8'h0C;
  localparam logic [7:0] PCH_OFS_BASE   = 8'h10;
  localparam logic [7:0] PCH_OFS_BOARD  = 8'h2C;
  localparam logic [7:0] PCH_OFS_CAPPTR = 8'h34;
  localparam logic [7:0] PCH_OFS_IRQ    = 8'h3C;
  localparam logic [7:0] PCH_OFS_CTRL   = 8'h40;
  localparam logic [7:0] PCH_OFS_PDCAP  = 8'h44;

  // ---------------------------------------------------------------
  // fixed field values
  // ---------------------------------------------------------------
  localparam logic [23:0] PCH_CLASS_CODE  = 24'h040000;
  localparam logic [7:0]  PCH_HDR_TYPE    = 8'h80;
  localparam logic [11:0] PCH_BASE_LOW    = 12'h008;
  localparam logic [7:0]  PCH_CAP_PTR     = 8'h44;
  localparam logic [6:0]  PCH_MAX_LAT     = 7'h28;
  localparam logic [8:0]  PCH_MIN_GNT     = 9'h010;
  localparam logic [7:0]  PCH_IRQ_PIN     = 8'h01;
  localparam logic [7:0]  PCH_PD_NEXT_PTR = 8'h4C;
  localparam logic [7:0]  PCH_PD_CAP_CODE = 8'h03;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          PCH_CTRL_VWE_BIT  = 0;
  localparam int          PCH_CTRL_CMB_BIT  = 1;
  localparam int          PCH_CTRL_CMA_BIT  = 2;
  localparam int          PCH_PD_FLAG_BIT   = 31;
  localparam logic [7:0]  PCH_LAT_RESET     = 8'h00;
  localparam logic [2:0]  PCH_CTRL_RESET    = 3'h0;
  localparam logic [15:0] PCH_BOARD_RESET   = 16'h0000;
  localparam logic [1:0]  PCH_PD_LAST_BYTE  = 2'h3;

  // configuration request from the host side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  dw_addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pch_cfg_req_type;

  // byte request to the eeprom controller
  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pch_ee_req_type;

  // transfer engine states, one-hot
  typedef enum logic [2:0] {
    PCH_PD_IDLE = 3'b001,
    PCH_PD_REQ  = 3'b010,
    PCH_PD_WAIT = 3'b100
  } pch_pd_state_type;

endpackage : pch_pkg

// file: pch_pd_engine.sv
`timescale 1ns/1ps

module pch_pd_engine
  import pch_pkg::*;
(
  // clock and reset
  input  wire logic           clock,
  input  wire logic           resetn,
  // start of a four byte transfer
  input  wire logic           start,
  input  wire logic           start_we,
  input  wire logic [7:0]     start_addr,
  input  wire logic [31:0]    word_in,
  // eeprom byte port
  output pch_ee_req_type      ee_q,
  input  wire logic           ee_ack,
  input  wire logic [7:0]     ee_rdata,
  // completion
  output logic                busy_q,
  output logic                rd_done_q,
  output logic                wr_done_q,
  output logic [31:0]         word_q
);

  pch_pd_state_type state_q;
  logic [1:0]       idx_q;
  logic             we_q;
  logic [7:0]       base_q;
  logic [31:0]      wr_word_q;

  // ---------------------------------------------------------------
  // byte sequencer
  // ---------------------------------------------------------------
  // one byte per handshake; req drops for a cycle between bytes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= PCH_PD_IDLE;
      idx_q     <= 2'h0;
      we_q      <= 1'b0;
      base_q    <= 8'h00;
      wr_word_q <= 32'h0000_0000;
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else begin
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
      case (state_q)
        PCH_PD_IDLE: begin
          if (start) begin
            we_q      <= start_we;
            base_q    <= start_addr;
            wr_word_q <= word_in;
            idx_q     <= 2'h0;
            state_q   <= PCH_PD_REQ;
          end
        end
        PCH_PD_REQ: begin
          state_q <= PCH_PD_WAIT;
        end
        PCH_PD_WAIT: begin
          if (ee_ack) begin
            if (idx_q == PCH_PD_LAST_BYTE) begin
              rd_done_q <= ~we_q;
              wr_done_q <= we_q;
              state_q   <= PCH_PD_IDLE;
            end else begin
              idx_q   <= idx_q + 2'h1;
              state_q <= PCH_PD_REQ;
            end
          end
        end
        default: begin
          state_q <= PCH_PD_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // eeprom request outputs
  // ---------------------------------------------------------------
  // lsb at base, msb at base plus three
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ee_q <= '0;
    end else begin
      ee_q.req   <= (state_q == PCH_PD_REQ) |
                    ((state_q == PCH_PD_WAIT) & ~ee_ack);
      ee_q.we    <= we_q;
      ee_q.addr  <= base_q + {6'h00, idx_q};
      ee_q.wdata <= wr_word_q[8*idx_q +: 8];
    end
  end

  // ---------------------------------------------------------------
  // read assembly and busy
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word_q <= 32'h0000_0000;
      busy_q <= 1'b0;
    end else begin
      if ((state_q == PCH_PD_WAIT) && ee_ack && !we_q) begin
        word_q[8*idx_q +: 8] <= ee_rdata;
      end
      busy_q <= (state_q != PCH_PD_IDLE) | start;
    end
  end

endmodule : pch_pd_engine

// file: pch_config_regs_monitor.sv
`timescale 1ns/1ps

module pch_config_regs_monitor
  import pch_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // configuration access
  input  pch_cfg_req_type  cfg,
  input  wire logic        cfg_ack_q,
  input  wire logic [31:0] cfg_rdata_q,
  // burst control
  input  wire logic        mst_burst,
  input  wire logic        gnt_n,
  input  wire logic        lat_expired_q,
  input  wire logic        burst_stop_q,
  // decode and shared control
  input  wire logic [19:0] mem_base_q,
  input  wire logic        compat_mode_a_enable_q,
  input  wire logic        compat_mode_b_enable_q,
  input  wire logic        board_vendor_write_enable_q,
  // product data and eeprom port
  input  wire logic        pd_word_load_q,
  input  pch_ee_req_type   ee_q,
  input  wire logic        ee_ack
);
  // -------------------------------------------------------------
  // read answers, stored fields and eeprom handshake
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_class_code: assert property (cfg.rd && cfg.dw_addr == 6'h02 |=>
    cfg_ack_q && cfg_rdata_q[31:8] == PCH_CLASS_CODE) else $error("class code wrong");
  chk_header_kind: assert property (cfg.rd && cfg.dw_addr == 6'h03 |=>
    cfg_rdata_q[31:16] == {8'h00, PCH_HDR_TYPE} && cfg_rdata_q[7:0] == 8'h00)
    else $error("header word wrong");
  chk_base_low: assert property (cfg.rd && cfg.dw_addr == 6'h04 |=>
    cfg_rdata_q[11:0] == PCH_BASE_LOW) else $error("base low bits wrong");
  chk_bus_needs: assert property (cfg.rd && cfg.dw_addr == 6'h0F |=>
    cfg_rdata_q[31:8] == {PCH_MAX_LAT, PCH_MIN_GNT, PCH_IRQ_PIN}) else $error("bus needs wrong");
  chk_cap_pointer: assert property (cfg.rd && cfg.dw_addr == 6'h0D |=>
    cfg_rdata_q == {24'h0, PCH_CAP_PTR}) else $error("capability pointer wrong");
  chk_pd_cap_id: assert property (cfg.rd && cfg.dw_addr == 6'h11 |=>
    cfg_rdata_q[15:0] == {PCH_PD_NEXT_PTR, PCH_PD_CAP_CODE} && cfg_rdata_q[30:24] == 7'h0)
    else $error("capability word wrong");
  chk_ctrl_reserved: assert property (cfg.rd && cfg.dw_addr == 6'h10 |=>
    cfg_rdata_q[31:3] == 29'h0) else $error("control reserved bits set");
  chk_base_store: assert property (cfg.wr && !cfg.rd && cfg.dw_addr == 6'h04 && cfg.be == 4'hF
    |=> mem_base_q == $past(cfg.wdata[31:12])) else $error("base not stored");
  // copies lag the register by one cycle, hence the extra delay
  chk_ctrl_copy: assert property (cfg.wr && !cfg.rd && cfg.dw_addr == 6'h10 && cfg.be[0]
    |=> ##1 {compat_mode_a_enable_q, compat_mode_b_enable_q, board_vendor_write_enable_q}
    == $past(cfg.wdata[2:0], 2)) else $error("shared control copy wrong");
  chk_byte_hold: assert property (ee_q.req && !ee_ack |=>
    ee_q.req && $stable(ee_q.addr) && $stable(ee_q.we)) else $error("byte request dropped");
  // one handshake per byte: the request is down the cycle after its answer
  chk_byte_gap: assert property (ee_ack |=> !ee_q.req)
    else $error("byte request not released after answer");
  chk_stop_cause: assert property ($rose(burst_stop_q) |->
    $past(lat_expired_q && gnt_n && mst_burst)) else $error("burst stop without cause");

  cover property (pd_word_load_q);
  cover property ($rose(burst_stop_q));
  cover property (ee_ack && ee_q.we);
endmodule : pch_config_regs_monitor

bind pch_config_regs pch_config_regs_monitor pch_config_regs_monitor_i (
  .clock(clock), .resetn(resetn), .cfg(cfg), .cfg_ack_q(cfg_ack_q),
  .cfg_rdata_q(cfg_rdata_q), .mst_burst(mst_burst), .gnt_n(gnt_n),
  .lat_expired_q(lat_expired_q), .burst_stop_q(burst_stop_q), .mem_base_q(mem_base_q),
  .compat_mode_a_enable_q(compat_mode_a_enable_q),
  .compat_mode_b_enable_q(compat_mode_b_enable_q),
  .board_vendor_write_enable_q(board_vendor_write_enable_q),
  .pd_word_load_q(pd_word_load_q), .ee_q(ee_q), .ee_ack(ee_ack));

// file: pch_ee_model.sv
`timescale 1ns/1ps

module pch_ee_model
  import pch_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // byte port from the device
  input  pch_ee_req_type  ee,
  output logic            ee_ack,
  output logic [7:0]      ee_rdata,
  // answer pace
  input  wire logic       slow
);
  // -------------------------------------------------------------
  // byte store
  // -------------------------------------------------------------
  logic [7:0] mem [256];
  logic [2:0] wait_q;

  // known pattern so reads can be predicted
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;

  // one answer per request; data toggles when idle so stale bytes never match
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ee_ack   <= 1'b0;
      ee_rdata <= 8'h00;
      wait_q   <= 3'h0;
    end else begin
      ee_ack   <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee.req && !ee_ack) begin
        if (wait_q == (slow ? 3'h4 : 3'h0)) begin
          ee_ack <= 1'b1;
          wait_q <= 3'h0;
          // byte lands at its own address
          if (ee.we) mem[ee.addr] <= ee.wdata;
          else ee_rdata <= mem[ee.addr];
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule : pch_ee_model

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top
  import pch_pkg::*;
;
  // -------------------------------------------------------------
  // bench signals, design and eeprom model
  // -------------------------------------------------------------
  logic            clock, resetn, mst_burst, gnt_n, slow, cfg_ack_q, pd_word_load_q, ee_ack;
  logic            lat_expired_q, burst_stop_q, mode_a, mode_b, vwe;
  pch_cfg_req_type cfg;
  pch_ee_req_type  ee_q;
  logic [31:0]     cfg_rdata_q, pd_word_in, pd_word_q, rd;
  logic [19:0]     mem_base_q;
  logic [7:0]      ee_rdata;
  int              errors, samples_checked, loads;
  localparam logic [5:0]  DWS [7] = '{6'h02, 6'h03, 6'h04, 6'h0D, 6'h0F, 6'h05, 6'h0E};
  localparam logic [31:0] EXP [7] = '{32'h04000001, 32'h0080FF00, 32'hFFFFF008,
                                      32'h00000044, 32'h501001FF, 32'h0, 32'h0};

  pch_config_regs #(.REVISION(8'h01)) pch_config_regs_i (
    .clock(clock), .resetn(resetn), .cfg(cfg), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .mst_burst(mst_burst), .gnt_n(gnt_n),
    .lat_expired_q(lat_expired_q), .burst_stop_q(burst_stop_q), .mem_base_q(mem_base_q),
    .compat_mode_a_enable_q(mode_a), .compat_mode_b_enable_q(mode_b),
    .board_vendor_write_enable_q(vwe), .pd_word_in(pd_word_in), .pd_word_q(pd_word_q),
    .pd_word_load_q(pd_word_load_q), .ee_q(ee_q), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

  pch_ee_model pch_ee_model_i (
    .clock(clock), .resetn(resetn), .ee(ee_q), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
    .slow(slow));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // read completion pulses, counted away from the edge that launches them
  always @(negedge clock) begin
    if (pd_word_load_q === 1'b1) loads++;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one config cycle; held for one edge, answer sampled the cycle after
  task access(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    @(posedge clock);
    #1 cfg = '{rd: !wr, wr: wr, dw_addr: dw, be: be, wdata: wd};
    @(posedge clock);
    #1 cfg.rd = 1'b0;
    cfg.wr = 1'b0;
    check("config ack", {31'h0, cfg_ack_q}, 32'h1);
    rd = cfg_rdata_q;
  endtask : access

  task rchk(input logic [5:0] dw, input logic [31:0] exp, input string what);
    access(1'b0, dw, 4'hF, 32'h0);
    check(what, rd, exp);
  endtask : rchk

  // bounded poll of the done flag
  task poll(input logic want);
    int n;
    n = 0;
    do begin
      access(1'b0, 6'h11, 4'hF, 32'h0);
      n++;
    end while (rd[31] !== want && n < 100);
    check("done flag", {31'h0, rd[31]}, {31'h0, want});
  endtask : poll

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #1_000_000;
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    cfg = '0;
    {mst_burst, gnt_n, slow} = 3'b000;
    pd_word_in = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    rchk(6'h03, 32'h00800000, "header at reset");
    rchk(6'h0F, 32'h50100100, "irq word at reset");
    rchk(6'h0B, 32'h0, "board ids at reset");
    rchk(6'h10, 32'h0, "control at reset");
    for (int i = 0; i < 7; i++) access(1'b1, DWS[i], 4'hF, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) rchk(DWS[i], EXP[i], "header field");
    check("base decode", {12'h0, mem_base_q}, 32'h000FFFFF);
    access(1'b1, 6'h04, 4'hF, 32'hABCDE123);
    rchk(6'h04, 32'hABCDE008, "base rewrite");
    $display("test fixed fields done");
    access(1'b1, 6'h0B, 4'hF, 32'h12345678);
    rchk(6'h0B, 32'h12340000, "vendor locked");
    for (int i = 0; i < 8; i++) begin
      access(1'b1, 6'h10, 4'h1, {29'h1FFFFFFF, i[2:0]});
      rchk(6'h10, {29'h0, i[2:0]}, "control byte");
      check("shared controls", {29'h0, mode_a, mode_b, vwe}, {29'h0, i[2:0]});
    end
    access(1'b1, 6'h0B, 4'hF, 32'h12345678);
    rchk(6'h0B, 32'h12345678, "vendor open");
    access(1'b1, 6'h10, 4'h1, 32'h0);
    access(1'b1, 6'h0B, 4'h3, 32'h0000FFFF);
    rchk(6'h0B, 32'h12345678, "vendor relocked");
    $display("test control done");
    // read from the top of the store, stray high address bits set
    access(1'b1, 6'h11, 4'hC, 32'h7FFC0000);
    poll(1'b1);
    check("read word", pd_word_q, 32'hA5A4A7A6);
    check("byte address", {24'h0, rd[23:16]}, 32'h000000FC);
    slow = 1'b1;
    pd_word_in = 32'hC3A51E77;
    access(1'b1, 6'h11, 4'hC, 32'h80100000);
    access(1'b1, 6'h11, 4'hC, 32'h80800000);
    poll(1'b0);
    check("busy start kept out", {24'h0, rd[23:16]}, 32'h00000010);
    for (int i = 0; i < 4; i++)
      check("stored byte", {24'h0, pch_ee_model_i.mem[8'h10 + i]}, {24'h0, pd_word_in[8*i +: 8]});
    check("untouched byte", {24'h0, pch_ee_model_i.mem[8'h80]}, 32'h000000DA);
    access(1'b1, 6'h11, 4'hC, 32'h00100000);
    poll(1'b1);
    check("read back", pd_word_q, 32'hC3A51E77);
    // address lane alone, then a start that reuses the stored address
    access(1'b1, 6'h11, 4'h4, 32'h00FC0000);
    access(1'b1, 6'h11, 4'h8, 32'h00000000);
    poll(1'b1);
    check("stored address read", pd_word_q, 32'hA5A4A7A6);
    check("load pulses", loads, 32'h3);
    $display("test product data done");
    access(1'b1, 6'h03, 4'h2, 32'h00000400);
    mst_burst = 1'b1;
    for (int n = 0; n < 20 && lat_expired_q !== 1'b1; n++) @(posedge clock) #1;
    check("latency expired", {31'h0, lat_expired_q}, 32'h1);
    check("stop held by grant", {31'h0, burst_stop_q}, 32'h0);
    gnt_n = 1'b1;
    repeat (2) @(posedge clock);
    #1 check("burst stop", {31'h0, burst_stop_q}, 32'h1);
    mst_burst = 1'b0;
    gnt_n = 1'b0;
    $display("test latency done");
    finish_test();
  end
endmodule : tb_top
